// *** hw/acogt_trim_bank.sv ***
// Trim register bank for the converter cores, with AXI4-Lite access.
// Assumes one clock, an on-chip fuse store and input-pair selects on aclk.
//
// Operation
// - Cores 4 and 5 add their 12-bit offset field, bits 11:0, to results.
// - Cores 0 to 4 apply their 5-bit fine-gain field, bits 4:0, to output.
// - Core 2 keeps pair A and B trim sets, uses the sampled one.
// - Core 3 keeps pair C and D trim sets, uses the sampled one.
// - Offset trim defaults load from fuse storage, not a constant.
// - Gain trim defaults load from fuse storage; software writes override.
// - Offset trim fields are treated as unsigned numbers.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acogt_trim_bank #(
    parameter int NUM_CORES = acogt_pkg::NUM_CORES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [acogt_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [acogt_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic fuse_req,
    output logic [acogt_pkg::SLOT_W-1:0] fuse_index,
    input wire logic [acogt_pkg::REG_W-1:0] fuse_data,
    input wire logic fuse_ack,
    output logic load_done,
    input wire logic core2_pair_b,
    input wire logic core3_pair_d,
    input wire acogt_pkg::acogt_sample_t sample_in [NUM_CORES],
    output acogt_pkg::acogt_result_t result_out [NUM_CORES]
);

    typedef enum logic [1:0] {
        W_ACCEPT = 2'h1,
        W_RESP = 2'h2
    } acogt_wr_state_t;

    typedef enum logic [1:0] {
        R_ADDR = 2'h1,
        R_DATA = 2'h2
    } acogt_rd_state_t;

    typedef struct packed {
        logic hit;
        logic [acogt_pkg::SLOT_W-1:0] slot;
    } acogt_decode_t;

    ////////////////////////////////////////////////////////////////////////
    function automatic acogt_decode_t decode(
        input logic [acogt_pkg::ADDR_W-1:0] addr
    );
        acogt_decode_t d;
        d.hit = 1'b0;
        d.slot = acogt_pkg::SLOT_OFFSET_TRIM_CORE4;
        for (int i = 0; i < acogt_pkg::NUM_REGS; i++) begin
            if (addr[acogt_pkg::ADDR_W-1:2] == acogt_pkg::REG_INDEX[i]) begin
                d.hit = 1'b1;
                d.slot = acogt_pkg::SLOT_W'(i);
            end
        end
        return d;
    endfunction

    // Reserved bits are never stored, so they always read back as zero
    function automatic logic [acogt_pkg::REG_W-1:0] field_mask(
        input logic [acogt_pkg::SLOT_W-1:0] slot
    );
        if (slot < acogt_pkg::SLOT_GAIN_TRIM_CORE0) begin
            return acogt_pkg::OFS_MASK;
        end else begin
            return acogt_pkg::GAIN_MASK;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic load_we;
    logic [acogt_pkg::REG_W-1:0] load_data;

    acogt_fuse_loader u_loader (
        .aclk(aclk),
        .aresetn(aresetn),
        .fuse_req(fuse_req),
        .fuse_index(fuse_index),
        .fuse_data(fuse_data),
        .fuse_ack(fuse_ack),
        .load_we(load_we),
        .load_data(load_data),
        .load_done(load_done)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [acogt_pkg::REG_W-1:0] regs [acogt_pkg::NUM_REGS];
    logic [acogt_pkg::REG_W-1:0] next_regs [acogt_pkg::NUM_REGS];
    acogt_wr_state_t wstate, next_wstate;
    logic aw_got, next_aw_got;
    logic w_got, next_w_got;
    logic [acogt_pkg::ADDR_W-1:0] waddr_q, next_waddr_q;
    logic [acogt_pkg::REG_W-1:0] wdata_q, next_wdata_q;
    logic [1:0] wstrb_q, next_wstrb_q;
    logic next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    localparam logic [acogt_pkg::REG_W-1:0] REG_RESET_W = acogt_pkg::REG_RESET;
    acogt_decode_t wdec;
    logic [acogt_pkg::REG_W-1:0] merged;

    always_comb begin
        next_regs = regs;
        next_wstate = wstate;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_waddr_q = waddr_q;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        wdec = decode(waddr_q);
        merged = REG_RESET_W;
        if (load_we) begin
            next_regs[fuse_index] = load_data & field_mask(fuse_index);
        end
        case (wstate)
            W_ACCEPT: begin
                if (awvalid && awready) begin
                    next_aw_got = 1'b1;
                    next_waddr_q = awaddr;
                end
                if (wvalid && wready) begin
                    next_w_got = 1'b1;
                    next_wdata_q = wdata[acogt_pkg::REG_W-1:0];
                    next_wstrb_q = wstrb[1:0];
                end
                if (next_aw_got && next_w_got) begin
                    wdec = decode(next_waddr_q);
                    next_aw_got = 1'b0;
                    next_w_got = 1'b0;
                    next_bvalid = 1'b1;
                    next_wstate = W_RESP;
                    if (wdec.hit) begin
                        merged = regs[wdec.slot];
                        if (next_wstrb_q[0]) begin
                            merged[7:0] = next_wdata_q[7:0];
                        end
                        if (next_wstrb_q[1]) begin
                            merged[15:8] = next_wdata_q[15:8];
                        end
                        // Reserved bits dropped, whatever software sent
                        next_regs[wdec.slot] = merged &
                            field_mask(wdec.slot);
                        next_bresp = acogt_pkg::RESP_OKAY;
                    end else begin
                        next_bresp = acogt_pkg::RESP_SLVERR;
                    end
                end
            end
            W_RESP: begin
                if (bready) begin
                    next_bvalid = 1'b0;
                    next_wstate = W_ACCEPT;
                end
            end
            default: begin
                next_wstate = W_ACCEPT;
            end
        endcase
        // Writes wait for the fuse walk so defaults never clobber software
        next_awready = load_done && (next_wstate == W_ACCEPT) && !next_aw_got;
        next_wready = load_done && (next_wstate == W_ACCEPT) && !next_w_got;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < acogt_pkg::NUM_REGS; i++) begin
                regs[i] <= acogt_pkg::REG_RESET;
            end
            wstate <= W_ACCEPT;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            waddr_q <= '0;
            wdata_q <= acogt_pkg::REG_RESET;
            wstrb_q <= 2'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= acogt_pkg::RESP_OKAY;
        end else begin
            regs <= next_regs;
            wstate <= next_wstate;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            waddr_q <= next_waddr_q;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    acogt_rd_state_t rstate, next_rstate;
    logic next_arready, next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    acogt_decode_t rdec;

    always_comb begin
        next_rstate = rstate;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        rdec = decode(araddr);
        case (rstate)
            R_ADDR: begin
                if (arvalid && arready) begin
                    next_rstate = R_DATA;
                    next_rvalid = 1'b1;
                    if (rdec.hit) begin
                        next_rdata = {16'h0000, regs[rdec.slot]};
                        next_rresp = acogt_pkg::RESP_OKAY;
                    end else begin
                        next_rdata = 32'h00000000;
                        next_rresp = acogt_pkg::RESP_SLVERR;
                    end
                end
            end
            R_DATA: begin
                if (rready) begin
                    next_rvalid = 1'b0;
                    next_rstate = R_ADDR;
                end
            end
            default: begin
                next_rstate = R_ADDR;
            end
        endcase
        next_arready = (next_rstate == R_ADDR);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rstate <= R_ADDR;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= acogt_pkg::RESP_OKAY;
        end else begin
            rstate <= next_rstate;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cores without a field in this bank run with zero trim
    acogt_pkg::acogt_trim_t trim [NUM_CORES];

    always_comb begin
        for (int c = 0; c < NUM_CORES; c++) begin
            trim[c] = '0;
        end
        trim[0].gain = regs[acogt_pkg::SLOT_GAIN_TRIM_CORE0][acogt_pkg::GAIN_W-1:0];
        trim[1].gain = regs[acogt_pkg::SLOT_GAIN_TRIM_CORE1][acogt_pkg::GAIN_W-1:0];
        // Pair select switches sets immediately; no glitch guard needed
        trim[2].gain = core2_pair_b ?
            regs[acogt_pkg::SLOT_GAIN_TRIM_CORE2_INPUT_B][acogt_pkg::GAIN_W-1:0] :
            regs[acogt_pkg::SLOT_GAIN_TRIM_CORE2_INPUT_A][acogt_pkg::GAIN_W-1:0];
        trim[3].gain = core3_pair_d ?
            regs[acogt_pkg::SLOT_GAIN_TRIM_CORE3_INPUT_D][acogt_pkg::GAIN_W-1:0] :
            regs[acogt_pkg::SLOT_GAIN_TRIM_CORE3_INPUT_C][acogt_pkg::GAIN_W-1:0];
        trim[4].gain = regs[acogt_pkg::SLOT_GAIN_TRIM_CORE4][acogt_pkg::GAIN_W-1:0];
        trim[4].offset = regs[acogt_pkg::SLOT_OFFSET_TRIM_CORE4][acogt_pkg::OFS_W-1:0];
        trim[5].offset = regs[acogt_pkg::SLOT_OFFSET_TRIM_CORE5][acogt_pkg::OFS_W-1:0];
    end

    for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
        acogt_core_trim u_core (
            .aclk(aclk),
            .aresetn(aresetn),
            .sample_in(sample_in[c]),
            .trim(trim[c]),
            .result_out(result_out[c])
        );
    end

endmodule
`default_nettype wire

// *** inc/acogt_pkg.sv ***
// Package for the core offset and fine-gain trim bank.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
package acogt_pkg;

    localparam int NUM_REGS = 9;
    localparam int NUM_CORES = 6;
    localparam int SLOT_W = 4;
    localparam int ADDR_W = 12;
    localparam int REG_W = 16;
    localparam int OFS_W = 12;
    localparam int GAIN_W = 5;
    localparam int SAMPLE_W = 9;
    localparam int SUM_W = 13;
    localparam int OUT_W = 14;
    // Fine gain step is 2^-GAIN_FRAC of the corrected value
    localparam int GAIN_FRAC = 10;
    localparam int PROD_W = SUM_W + GAIN_W;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_OFFSET_TRIM_CORE4 = 10'h33C;
    localparam logic [9:0] IDX_OFFSET_TRIM_CORE5 = 10'h33E;
    localparam logic [9:0] IDX_GAIN_TRIM_CORE0 = 10'h360;
    localparam logic [9:0] IDX_GAIN_TRIM_CORE1 = 10'h361;
    localparam logic [9:0] IDX_GAIN_TRIM_CORE2_INPUT_A = 10'h362;
    localparam logic [9:0] IDX_GAIN_TRIM_CORE2_INPUT_B = 10'h363;
    localparam logic [9:0] IDX_GAIN_TRIM_CORE3_INPUT_C = 10'h364;
    localparam logic [9:0] IDX_GAIN_TRIM_CORE3_INPUT_D = 10'h365;
    localparam logic [9:0] IDX_GAIN_TRIM_CORE4 = 10'h366;

    // Storage slots, same order as the fuse words
    localparam logic [SLOT_W-1:0] SLOT_OFFSET_TRIM_CORE4 = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_OFFSET_TRIM_CORE5 = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_GAIN_TRIM_CORE0 = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_GAIN_TRIM_CORE1 = 4'h3;
    localparam logic [SLOT_W-1:0] SLOT_GAIN_TRIM_CORE2_INPUT_A = 4'h4;
    localparam logic [SLOT_W-1:0] SLOT_GAIN_TRIM_CORE2_INPUT_B = 4'h5;
    localparam logic [SLOT_W-1:0] SLOT_GAIN_TRIM_CORE3_INPUT_C = 4'h6;
    localparam logic [SLOT_W-1:0] SLOT_GAIN_TRIM_CORE3_INPUT_D = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_GAIN_TRIM_CORE4 = 4'h8;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 4'h8;

    localparam logic [9:0] REG_INDEX [NUM_REGS] = '{
        IDX_OFFSET_TRIM_CORE4, IDX_OFFSET_TRIM_CORE5,
        IDX_GAIN_TRIM_CORE0, IDX_GAIN_TRIM_CORE1,
        IDX_GAIN_TRIM_CORE2_INPUT_A, IDX_GAIN_TRIM_CORE2_INPUT_B,
        IDX_GAIN_TRIM_CORE3_INPUT_C, IDX_GAIN_TRIM_CORE3_INPUT_D,
        IDX_GAIN_TRIM_CORE4};

    localparam logic [REG_W-1:0] OFS_MASK = 16'h0FFF;
    localparam logic [REG_W-1:0] GAIN_MASK = 16'h001F;
    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [OFS_W-1:0] offset;
        logic [GAIN_W-1:0] gain;
    } acogt_trim_t;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } acogt_sample_t;

    typedef struct packed {
        logic valid;
        logic [OUT_W-1:0] data;
    } acogt_result_t;

endpackage

// *** hw/acogt_fuse_loader.sv ***
// Walks the fuse store once after reset and hands each default word over.
// Assumes a fuse store on the same clock answering req with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module acogt_fuse_loader (
    input wire logic aclk,
    input wire logic aresetn,
    output logic fuse_req,
    output logic [acogt_pkg::SLOT_W-1:0] fuse_index,
    input wire logic [acogt_pkg::REG_W-1:0] fuse_data,
    input wire logic fuse_ack,
    output logic load_we,
    output logic [acogt_pkg::REG_W-1:0] load_data,
    output logic load_done
);

    typedef enum logic [2:0] {
        L_REQ = 3'h1,
        L_WAIT = 3'h2,
        L_DONE = 3'h4
    } acogt_load_state_t;

    acogt_load_state_t state, next_state;
    logic next_fuse_req;
    logic [acogt_pkg::SLOT_W-1:0] next_fuse_index;
    logic next_load_we;
    logic [acogt_pkg::REG_W-1:0] next_load_data;
    logic next_load_done;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_fuse_req = fuse_req;
        next_fuse_index = fuse_index;
        next_load_we = 1'b0;
        next_load_data = load_data;
        next_load_done = load_done;
        case (state)
            L_REQ: begin
                next_fuse_req = 1'b1;
                next_state = L_WAIT;
                // Step only once the word this index named is stored
                if (load_we) begin
                    next_fuse_index = fuse_index + 4'h1;
                end
            end
            L_WAIT: begin
                if (fuse_ack) begin
                    next_fuse_req = 1'b0;
                    next_load_we = 1'b1;
                    next_load_data = fuse_data;
                    if (fuse_index == acogt_pkg::SLOT_LAST) begin
                        next_state = L_DONE;
                        next_load_done = 1'b1;
                    end else begin
                        next_state = L_REQ;
                    end
                end
            end
            default: begin
                next_state = L_DONE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= L_REQ;
            fuse_req <= 1'b0;
            fuse_index <= acogt_pkg::SLOT_OFFSET_TRIM_CORE4;
            load_we <= 1'b0;
            load_data <= acogt_pkg::REG_RESET;
            load_done <= 1'b0;
        end else begin
            state <= next_state;
            fuse_req <= next_fuse_req;
            fuse_index <= next_fuse_index;
            load_we <= next_load_we;
            load_data <= next_load_data;
            load_done <= next_load_done;
        end
    end

endmodule
`default_nettype wire

// *** hw/acogt_core_trim.sv ***
// Offset and fine-gain correction for one converter core.
// Assumes samples and trim come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module acogt_core_trim (
    input wire logic aclk,
    input wire logic aresetn,
    input wire acogt_pkg::acogt_sample_t sample_in,
    input wire acogt_pkg::acogt_trim_t trim,
    output acogt_pkg::acogt_result_t result_out
);

    acogt_pkg::acogt_result_t next_result;
    logic [acogt_pkg::SUM_W-1:0] sum;
    logic [acogt_pkg::PROD_W-1:0] prod;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Offset is unsigned, so it only ever raises the code
        sum = acogt_pkg::SUM_W'(sample_in.data) +
              acogt_pkg::SUM_W'(trim.offset);
        prod = acogt_pkg::PROD_W'(sum) * acogt_pkg::PROD_W'(trim.gain);
        next_result.valid = sample_in.valid;
        next_result.data = acogt_pkg::OUT_W'(sum) +
            acogt_pkg::OUT_W'(prod >> acogt_pkg::GAIN_FRAC);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_out <= '0;
        end else begin
            result_out <= next_result;
        end
    end

endmodule
`default_nettype wire

// *** dv/acogt_trim_bank_props.sv ***
// Assertions on the ports of the trim bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module acogt_trim_bank_props #(
    parameter int NUM_CORES = acogt_pkg::NUM_CORES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic fuse_req,
    input wire logic [acogt_pkg::SLOT_W-1:0] fuse_index,
    input wire logic fuse_ack,
    input wire logic load_done,
    input wire logic core2_pair_b,
    input wire logic core3_pair_d,
    input wire acogt_pkg::acogt_sample_t sample_in [NUM_CORES],
    input wire acogt_pkg::acogt_result_t result_out [NUM_CORES]
);
default clocking dc @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////
// Core 5 has no gain, so the sum is bounded by a 12-bit offset
property p_offset_trim_core5;
    sample_in[5].valid |=> result_out[5].valid &&
        result_out[5].data >= $past(sample_in[5].data) &&
        result_out[5].data <= $past(sample_in[5].data) + 14'h0FFF;
endproperty
a_offset_trim_core5: assert property (p_offset_trim_core5)
    else $error("core 5 result outside offset range");
// Core 0 has no offset; 31/1024 of at most 511 adds 15
property p_gain_trim_core0;
    sample_in[0].valid |=> result_out[0].data >= $past(sample_in[0].data)
        && result_out[0].data <= $past(sample_in[0].data) + 14'h000F;
endproperty
a_gain_trim_core0: assert property (p_gain_trim_core0)
    else $error("core 0 result outside gain range");
property p_offset_trim_core4;
    sample_in[4].valid |=> result_out[4].data >= $past(sample_in[4].data);
endproperty
a_offset_trim_core4: assert property (p_offset_trim_core4)
    else $error("core 4 result below its sample");
property p_c2;
    load_done && $stable(sample_in[2]) && $stable(core2_pair_b) &&
        !$past(wvalid && wready) && !$past(awvalid && awready)
        |=> $stable(result_out[2]);
endproperty
a_c2: assert property (p_c2)
    else $error("core 2 result moved with steady input and select");
property p_c3;
    load_done && $stable(sample_in[3]) && $stable(core3_pair_d) &&
        !$past(wvalid && wready) && !$past(awvalid && awready)
        |=> $stable(result_out[3]);
endproperty
a_c3: assert property (p_c3)
    else $error("core 3 result moved with steady input and select");
property p_fuse_hold;
    fuse_req && !fuse_ack |=> fuse_req && $stable(fuse_index);
endproperty
a_fuse_hold: assert property (p_fuse_hold)
    else $error("fuse request dropped before answer");
property p_load_end;
    $rose(load_done) |-> fuse_index == acogt_pkg::SLOT_LAST &&
        ($past(fuse_ack) || $past(fuse_ack, 2));
endproperty
a_load_end: assert property (p_load_end)
    else $error("load finished without last fuse word");
// Writes held off so a late fuse word cannot clobber software
property p_gate;
    !load_done |-> !awready && !wready;
endproperty
a_gate: assert property (p_gate)
    else $error("write accepted before defaults loaded");
property p_wr_ans;
    awvalid && awready && wvalid && wready |=> bvalid;
endproperty
a_wr_ans: assert property (p_wr_ans)
    else $error("no write response after both taken");
property p_rd_ans;
    arvalid && arready |=> rvalid;
endproperty
a_rd_ans: assert property (p_rd_ans)
    else $error("no read data after address taken");
property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
endproperty
a_rhold: assert property (p_rhold)
    else $error("read data changed while stalled");
property p_resv;
    rvalid |-> rdata[31:16] == 16'h0000;
endproperty
a_resv: assert property (p_resv)
    else $error("upper read bits not zero");
endmodule
bind acogt_trim_bank acogt_trim_bank_props #(.NUM_CORES(NUM_CORES)) u_props (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .fuse_req(fuse_req), .fuse_index(fuse_index), .fuse_ack(fuse_ack),
    .load_done(load_done), .core2_pair_b(core2_pair_b),
    .core3_pair_d(core3_pair_d), .sample_in(sample_in),
    .result_out(result_out));
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the trim bank over AXI4-Lite.
// Assumes the package is compiled first; the bench plays the fuse store.
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
logic rready = 1'b0, fuse_ack = 1'b0, core2_pair_b = 1'b0;
logic core3_pair_d = 1'b0;
logic awready, wready, bvalid, arready, rvalid, fuse_req, load_done;
logic [11:0] awaddr = 12'h000, araddr = 12'h000;
logic [31:0] wdata = 32'h00000000, rdata, rd;
logic [3:0] wstrb = 4'h0;
logic [1:0] bresp, rresp, resp;
logic [acogt_pkg::SLOT_W-1:0] fuse_index;
logic [15:0] fuse_data = 16'h0000;
logic [7:0] fwait = 8'h00;
acogt_pkg::acogt_sample_t sample_in [acogt_pkg::NUM_CORES];
acogt_pkg::acogt_result_t result_out [acogt_pkg::NUM_CORES];
int err_total = 0;
int compares = 0;
logic [15:0] cur [9];
logic [15:0] fw [9] = '{16'h0A5C, 16'h0FFF, 16'h0011, 16'h001F, 16'h0003,
    16'h0007, 16'h000C, 16'h0015, 16'h0001};
logic [15:0] wv [9] = '{16'h0FFF, 16'h0123, 16'h001F, 16'h0000, 16'h0010,
    16'h0005, 16'h001E, 16'h0009, 16'h0011};
logic [8:0] sv [3] = '{9'h1FF, 9'h000, 9'h0A7};
always #2.5 aclk = ~aclk;
////////////////////////////////////////
// Slow fuse store; data scrambled outside the answer cycle
always @(posedge aclk) begin
    fuse_ack <= 1'b0;
    fuse_data <= ~fuse_data;
    if (fuse_req && !fuse_ack) begin
        fwait <= fwait + 8'h01;
        if (fwait == 8'h13) begin
            fuse_ack <= 1'b1;
            fuse_data <= fw[fuse_index];
            fwait <= 8'h00;
        end
    end
end
acogt_trim_bank DUT (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .fuse_req(fuse_req),
    .fuse_index(fuse_index), .fuse_data(fuse_data), .fuse_ack(fuse_ack),
    .load_done(load_done), .core2_pair_b(core2_pair_b),
    .core3_pair_d(core3_pair_d), .sample_in(sample_in),
    .result_out(result_out));
////////////////////////////////////////
task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
        err_total++;
        $display("BAD %s expected %h seen %h", w, e, s);
    end
endtask
function automatic logic [11:0] ba(input int i);
    return {acogt_pkg::REG_INDEX[i], 2'b00};
endfunction
task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
endtask
task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
endtask
// Expected result: (s + ofs) plus (s + ofs) * gain / 1024
function automatic logic [13:0] exp_res(input logic [8:0] s,
    input logic [15:0] o, input logic [15:0] g);
    logic [12:0] sum;
    logic [17:0] p;
    sum = {4'h0, s} + {1'b0, o[11:0]};
    p = sum * g[4:0];
    return {1'b0, sum} + {6'h00, p[17:10]};
endfunction
task automatic run_samples();
    logic [15:0] o;
    logic [15:0] g;
    for (int p = 0; p < 4; p++) begin
        for (int k = 0; k < 3; k++) begin
            @(posedge aclk);
            core2_pair_b <= p[0];
            core3_pair_d <= p[1];
            for (int c = 0; c < 6; c++) sample_in[c] <= {k != 1, sv[k]};
            @(posedge aclk);
            #1;
            for (int c = 0; c < 6; c++) begin
                o = c == 4 ? cur[0] : c == 5 ? cur[1] : 16'h0000;
                g = c == 0 ? cur[2] : c == 1 ? cur[3] : c == 2 ?
                    cur[4 + p[0]] : c == 3 ? cur[6 + p[1]] :
                    c == 4 ? cur[8] : 16'h0000;
                chk("result", result_out[c], {k != 1, exp_res(sv[k], o, g)});
            end
        end
    end
endtask
task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
////////////////////////////////////////
initial begin
    #100000;
    err_total++;
    print_verdict();
end
initial begin
    foreach (sample_in[i]) sample_in[i] = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Last fuse word cannot have landed yet
    axi_rd(ba(8));
    chk("reset value", rd, 32'h00000000);
    for (int n = 0; n < 1000 && load_done !== 1'b1; n++) @(posedge aclk);
    chk("load_done", load_done, 32'h00000001);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
        axi_rd(ba(i));
        cur[i] = fw[i];
        chk("fuse default", rd, {16'h0000, fw[i]});
    end
    run_samples();
    $display("test fuse defaults done");
    for (int i = 0; i < 9; i++) begin
        axi_wr(ba(i), {16'h0000, wv[i]}, 4'hF);
        cur[i] = wv[i];
        chk("write resp", resp, acogt_pkg::RESP_OKAY);
    end
    axi_wr(ba(1), 32'h00000045, 4'h1);
    cur[1] = {cur[1][15:8], 8'h45};
    axi_wr(ba(0), 32'h00000A00, 4'h2);
    cur[0] = {8'h0A, cur[0][7:0]};
    for (int i = 0; i < 9; i++) begin
        axi_rd(ba(i));
        chk("readback", rd, {16'h0000, cur[i]});
    end
    run_samples();
    $display("test software override done");
    axi_wr(12'hD9C, 32'h0000001F, 4'hF);
    chk("unmapped write resp", resp, acogt_pkg::RESP_SLVERR);
    axi_rd(12'hD9C);
    chk("unmapped read", rd, 32'h00000000);
    chk("unmapped read resp", resp, acogt_pkg::RESP_SLVERR);
    $display("test unmapped done");
    print_verdict();
end
endmodule
`default_nettype wire
